// *** sep_eeprom.sv ***
`timescale 1ns/1ps
`default_nettype none

module sep_eeprom #(
   parameter int unsigned WR_CYCLES = sep_pkg::WR_CYCLE_CNT
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic sck_i,
   input  wire logic cs_n_i,
   input  wire logic si_i,
   input  wire logic hold_n_i,
   input  wire logic wp_n_i,
   output logic      so_o,
   output logic      so_oe_o
);
   import sep_pkg::*;

   // ---------------- link domain (serial clock) ----------------
   sep_link_state_t st;
   sep_link_state_t next_st;
   logic [2:0]        bitcnt;
   logic [6:0]        shin;
   logic              addr_second;
   logic [7:0]        addr_hi;
   logic              rd_mode;
   logic [ADDR_W-1:0] rd_addr;
   logic [ADDR_W-1:0] next_rd_addr;
   logic              ld_mem;
   logic              ld_stat;
   logic              next_ld_mem;
   logic              next_ld_stat;
   logic              adv;
   logic              next_rd_mode;
   logic              next_addr_second;
   logic [7:0]        next_addr_hi;
   logic [7:0]        tx;
   logic [7:0]        mem_rd;
   logic [7:0]        stat_m;
   logic [7:0]        stat_l;
   logic [7:0]        status;

   // hand-over registers, kept across the end of a frame
   sep_cmd_t         kind;
   sep_cmd_t         next_kind;
   logic             armed;
   logic             next_armed;
   logic [7:0]       stat_data;
   logic [7:0]       next_stat_data;
   logic [BASE_W-1:0] page_base;
   logic [BASE_W-1:0] next_page_base;
   logic [PAGE_W-1:0] page_lo;
   logic [PAGE_W-1:0] next_page_lo;
   logic [PAGE_BYTES-1:0] mask;
   logic [PAGE_BYTES-1:0] next_mask;
   logic              pb_we;

   // deselect or reset clears the frame logic at once
   wire link_clr = cs_n_i | rst_i;

   // byte assembly, MSB first
   wire [7:0] byte_in   = {shin, si_i};
   wire       byte_done = (bitcnt == 3'h7);
   wire [7:0] opcode    = byte_in & OP_MASK;
   wire       first_bit = (st == LS_OPCODE) && (bitcnt == 3'h0);
   wire       busy_l    = stat_l[SR_BUSY_BIT];
   wire [ADDR_W-1:0] start_addr = {addr_hi[ADDR_W-9:0], byte_in};

   // array read address: the start address on the last address bit
   wire [ADDR_W-1:0] arr_raddr =
      (st == LS_ADDR) ? start_addr : rd_addr;
   wire out_state = (st == LS_STAT) || (st == LS_RDATA);
   wire [7:0] tx_src = ld_mem ? mem_rd : (ld_stat ? stat_l : tx);

   // link sequencer
   always_comb begin
      next_st          = st;
      next_ld_mem      = 1'b0;
      next_ld_stat     = 1'b0;
      next_rd_mode     = rd_mode;
      next_addr_second = addr_second;
      next_addr_hi     = addr_hi;
      next_rd_addr     = rd_addr;
      next_kind        = kind;
      next_armed       = first_bit ? 1'b0 : armed;
      next_stat_data   = stat_data;
      next_page_base   = page_base;
      next_page_lo     = page_lo;
      next_mask        = first_bit ? {PAGE_BYTES{1'b0}} : mask;
      pb_we            = 1'b0;
      case (st)
         LS_OPCODE: begin
            if (byte_done) begin
               if (busy_l && (opcode != OP_STAT_RD)) begin
                  next_st = LS_IGNORE;
               end else begin
                  case (opcode)
                     OP_SET_LATCH: begin
                        next_kind  = CK_SET;
                        next_armed = 1'b1;
                        next_st    = LS_IGNORE;
                     end
                     OP_CLR_LATCH: begin
                        next_kind  = CK_CLR;
                        next_armed = 1'b1;
                        next_st    = LS_IGNORE;
                     end
                     OP_STAT_RD: begin
                        next_st      = LS_STAT;
                        next_ld_stat = 1'b1;
                     end
                     OP_STAT_WR: begin
                        next_kind = CK_STAT;
                        next_st   = LS_SWR;
                     end
                     OP_ARRAY_RD: begin
                        next_rd_mode = 1'b1;
                        next_st      = LS_ADDR;
                     end
                     OP_ARRAY_WR: begin
                        next_kind    = CK_PAGE;
                        next_rd_mode = 1'b0;
                        next_st      = LS_ADDR;
                     end
                     default: begin
                        next_st = LS_IGNORE;
                     end
                  endcase
               end
            end
         end
         LS_ADDR: begin
            if (byte_done && !addr_second) begin
               next_addr_second = 1'b1;
               next_addr_hi     = byte_in;
            end else if (byte_done && rd_mode) begin
               next_rd_addr = start_addr + 14'h0001;
               next_ld_mem  = 1'b1;
               next_st      = LS_RDATA;
            end else if (byte_done) begin
               next_page_base = start_addr[ADDR_W-1:PAGE_W];
               next_page_lo   = start_addr[PAGE_W-1:0];
               next_st        = LS_WDATA;
            end
         end
         LS_RDATA: begin
            if (byte_done) begin
               // 14-bit counter rolls from the top address to zero
               next_rd_addr = rd_addr + 14'h0001;
               next_ld_mem  = 1'b1;
            end
         end
         LS_STAT: begin
            next_ld_stat = byte_done;
         end
         LS_SWR: begin
            if (byte_done) begin
               next_stat_data = byte_in;
               next_armed     = 1'b1;
               next_st        = LS_TAIL;
            end
         end
         LS_WDATA: begin
            // armed only right after a whole data byte
            next_armed = byte_done;
            if (byte_done) begin
               pb_we        = 1'b1;
               next_mask    = mask | (64'h0000000000000001 << page_lo);
               next_page_lo = page_lo + 6'h01;
            end
         end
         LS_TAIL: begin
            next_armed = 1'b0;
            next_st    = LS_IGNORE;
         end
         LS_IGNORE: begin
            next_st = LS_IGNORE;
         end
         default: begin
            next_st = LS_IGNORE;
         end
      endcase
   end

   // frame-local state, rising edge; suspend freezes everything except adv, which clears
   always_ff @(posedge sck_i or posedge link_clr) begin
      if (link_clr) begin
         st          <= LS_OPCODE;
         bitcnt      <= 3'h0;
         shin        <= 7'h00;
         addr_second <= 1'b0;
         addr_hi     <= 8'h00;
         rd_mode     <= 1'b0;
         rd_addr     <= 14'h0000;
         ld_mem      <= 1'b0;
         ld_stat     <= 1'b0;
         adv         <= 1'b0;
      end else if (hold_n_i) begin
         st          <= next_st;
         bitcnt      <= bitcnt + 3'h1;
         shin        <= byte_in[6:0];
         addr_second <= next_addr_second;
         addr_hi     <= next_addr_hi;
         rd_mode     <= next_rd_mode;
         rd_addr     <= next_rd_addr;
         ld_mem      <= next_ld_mem;
         ld_stat     <= next_ld_stat;
         adv         <= 1'b1;
      end else begin
         adv <= 1'b0;
      end
   end

   // hand-over registers; only system reset clears them all, armed and mask also clear on the first edge of a frame
   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         kind      <= CK_CLR;
         armed     <= 1'b0;
         stat_data <= 8'h00;
         page_base <= 8'h00;
         page_lo   <= 6'h00;
         mask      <= {PAGE_BYTES{1'b0}};
      end else if (hold_n_i && !cs_n_i) begin
         kind      <= next_kind;
         armed     <= next_armed;
         stat_data <= next_stat_data;
         page_base <= next_page_base;
         page_lo   <= next_page_lo;
         mask      <= next_mask;
      end
   end

   // status byte crossing into the link domain, two flops per bit
   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         stat_m <= 8'h00;
         stat_l <= 8'h00;
      end else begin
         stat_m <= status;
         stat_l <= stat_m;
      end
   end

   // output shifter on the falling edge, mode 0 and 3 alike
   always_ff @(negedge sck_i or posedge link_clr) begin
      if (link_clr) begin
         tx      <= 8'h00;
         so_o    <= 1'b0;
         so_oe_o <= 1'b0;
      end else begin
         so_oe_o <= out_state && hold_n_i;
         if (adv) begin
            so_o <= tx_src[7];
            tx   <= {tx_src[6:0], 1'b0};
         end
      end
   end

   // ---------------- system domain ----------------
   logic              cs_m;
   logic              cs_s;
   logic              cs_d;
   logic              wp_m;
   logic              wp_s;
   logic              wel;
   logic [1:0]        guard;
   logic              arm;
   logic              busy;
   logic [31:0]       timer;
   logic              abort_swr;
   logic              copy_act;
   logic              copy_act_d;
   logic [PAGE_W:0]   copy_idx;
   logic [PAGE_W-1:0] copy_idx_d;
   logic [PAGE_BYTES-1:0] mask_q;
   logic [BASE_W-1:0] base_q;
   logic [7:0]        pb_rd;

   // pin synchronisers; edge logic compares the second stage with its delayed third stage
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cs_m <= 1'b1;
         cs_s <= 1'b1;
         cs_d <= 1'b1;
         wp_m <= 1'b1;
         wp_s <= 1'b1;
      end else begin
         cs_m <= cs_n_i;
         cs_s <= cs_m;
         cs_d <= cs_s;
         wp_m <= wp_n_i;
         wp_s <= wp_m;
      end
   end

   // commit decode; link registers are static once select is high
   wire cs_rise  = cs_s && !cs_d;
   wire cs_fall  = !cs_s && cs_d;
   wire hw_prot  = !wp_s && arm;
   wire commit   = cs_rise && armed && !busy;
   wire page_top2 = page_base[BASE_W-1:BASE_W-2] == 2'h3;
   wire page_top1 = page_base[BASE_W-1];
   wire page_guarded = (guard == GUARD_ALL) ||
                       ((guard == GUARD_HALF) && page_top1) ||
                       ((guard == GUARD_QUARTER) && page_top2);
   wire do_set   = commit && (kind == CK_SET);
   wire do_clr   = commit && (kind == CK_CLR);
   wire do_swr   = commit && (kind == CK_STAT) && wel &&
                   !hw_prot && !abort_swr;
   wire do_page  = commit && (kind == CK_PAGE) && wel &&
                   !page_guarded && (mask != {PAGE_BYTES{1'b0}});
   wire timer_end = busy && (timer == 32'h00000001);
   wire arr_we   = copy_act_d && mask_q[copy_idx_d];

   // status byte as the link shifts it out
   assign status = busy ? SR_BUSY_VALUE :
                   {arm, 3'h0, guard, wel, 1'b0};

   // write latch, guard and arm fields
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wel   <= WEL_RESET;
         guard <= GUARD_RESET;
         arm   <= ARM_RESET;
      end else begin
         if (do_set) begin
            wel <= 1'b1;
         end else if (do_clr || timer_end) begin
            wel <= 1'b0;
         end
         if (do_swr) begin
            guard <= stat_data[SR_GUARD_HI_BIT:SR_GUARD_LO_BIT];
            arm   <= stat_data[SR_ARM_BIT];
         end
      end
   end

   // protect pin low mid-frame with arm set cancels a pending status write
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         abort_swr <= 1'b0;
      end else if (!cs_s && !wp_s && arm) begin
         abort_swr <= 1'b1;
      end else if (cs_fall) begin
         abort_swr <= 1'b0;
      end
   end

   // self-timed programming cycle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         busy  <= 1'b0;
         timer <= 32'h00000000;
      end else if (do_swr || do_page) begin
         busy  <= 1'b1;
         timer <= WR_CYCLES;
      end else if (busy) begin
         busy  <= !timer_end;
         timer <= timer - 32'h00000001;
      end
   end

   // page copy from the buffer into the array, one byte a cycle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         copy_act   <= 1'b0;
         copy_act_d <= 1'b0;
         copy_idx   <= 7'h00;
         copy_idx_d <= 6'h00;
         mask_q     <= {PAGE_BYTES{1'b0}};
         base_q     <= 8'h00;
      end else begin
         copy_act_d <= copy_act;
         copy_idx_d <= copy_idx[PAGE_W-1:0];
         if (do_page) begin
            copy_act <= 1'b1;
            copy_idx <= 7'h00;
            mask_q   <= mask;
            base_q   <= page_base;
         end else if (copy_act) begin
            copy_act <= (copy_idx != 7'h3F);
            copy_idx <= copy_idx + 7'h01;
         end
      end
   end

   // page buffer: filled by the link, drained by the system side
   sep_mem #(
      .W  (DATA_W),
      .AW (PAGE_W)
   ) u_page (
      .wclk_i  (sck_i),
      .we_i    (pb_we && hold_n_i && !cs_n_i),
      .waddr_i (page_lo),
      .wdata_i (byte_in),
      .rclk_i  (clk_sys_i),
      .raddr_i (copy_idx[PAGE_W-1:0]),
      .rdata_o (pb_rd)
   );

   // the array itself, read directly by the link
   sep_mem #(
      .W  (DATA_W),
      .AW (ADDR_W)
   ) u_array (
      .wclk_i  (clk_sys_i),
      .we_i    (arr_we),
      .waddr_i ({base_q, copy_idx_d}),
      .wdata_i (pb_rd),
      .rclk_i  (sck_i),
      .raddr_i (arr_raddr),
      .rdata_o (mem_rd)
   );

endmodule

`default_nettype wire

// *** sep_eeprom_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// pin-level watcher of the serial memory
module sep_eeprom_properties
   import sep_pkg::*;
#(
   parameter int unsigned WR_CYCLES = 200
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic hold_n_i,
   input wire logic wp_n_i,
   input wire logic so_o,
   input wire logic so_oe_o
);
   logic [9:0] n_edge;
   logic [7:0] op_seen;
   // accepted edges and opcode of a frame; saturates on long reads
   always_ff @(posedge sck_i or posedge cs_n_i or posedge rst_i) begin
      if (cs_n_i || rst_i) begin
         n_edge  <= 10'h000;
         op_seen <= 8'h00;
      end else if (hold_n_i && n_edge != 10'h3FF) begin
         n_edge <= n_edge + 10'h001;
         if (n_edge < 10'h008)
            op_seen <= {op_seen[6:0], si_i};
      end
   end
   // opcode decode, X bit masked
   wire logic [7:0] op_m  = op_seen & OP_MASK;
   wire logic       is_st = op_m == OP_STAT_RD;
   wire logic       is_rd = op_m == OP_ARRAY_RD;
   wire logic       op_in = n_edge >= 10'h008;
   wire logic       known = is_st || is_rd || op_m == OP_ARRAY_WR ||
      op_m == OP_STAT_WR || op_m == OP_SET_LATCH || op_m == OP_CLR_LATCH;
   sequence s_held;
      hold_n_i && $past(hold_n_i);
   endsequence
   sequence s_stat_on;
      is_st && op_in;
   endsequence
   property p_reset_quiet;
      @(posedge clk_sys_i) disable iff (rst_i)
         $fell(rst_i) |-> !so_oe_o && !so_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("output active right after reset");
   property p_desel_float;
      @(posedge clk_sys_i) disable iff (rst_i) cs_n_i |-> !so_oe_o;
   endproperty
   a_desel_float: assert property (p_desel_float)
      else $error("output driven while deselected");
   property p_fresh_frame;
      @(posedge clk_sys_i) disable iff (rst_i) $fell(cs_n_i) |-> !so_oe_o [*2];
   endproperty
   a_fresh_frame: assert property (p_fresh_frame)
      else $error("output driven at frame start");
   property p_hold_float;
      @(posedge sck_i) disable iff (rst_i) !hold_n_i |=> !so_oe_o;
   endproperty
   a_hold_float: assert property (p_hold_float)
      else $error("output driven while suspended");
   property p_opcode_quiet;
      @(posedge sck_i) disable iff (rst_i) !op_in |-> !so_oe_o;
   endproperty
   a_opcode_quiet: assert property (p_opcode_quiet)
      else $error("output driven during opcode");
   property p_bad_op;
      @(posedge sck_i) disable iff (rst_i) op_in && !known |-> !so_oe_o;
   endproperty
   a_bad_op: assert property (p_bad_op)
      else $error("output driven after unknown opcode");
   property p_oe_cause;
      @(posedge sck_i) disable iff (rst_i)
         so_oe_o |-> op_in && (is_st || (is_rd && n_edge >= 10'h018));
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("output driven outside a read data phase");
   property p_stat_drive;
      @(posedge sck_i) disable iff (rst_i) s_stat_on ##0 s_held |-> so_oe_o;
   endproperty
   a_stat_drive: assert property (p_stat_drive)
      else $error("status read not answered");
endmodule
bind sep_eeprom sep_eeprom_properties #(
   .WR_CYCLES(WR_CYCLES)
) i_sep_eeprom_properties (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
   .si_i(si_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o),
   .so_oe_o(so_oe_o)
);
`default_nettype wire

// *** sep_eeprom_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_tb;
   import sep_pkg::*;
   localparam int unsigned WR_N = 200; // short cycle, above page copy
   localparam logic [15:0] GA [3] = '{16'h3010, 16'h2010, 16'h4010};
   logic        clk_sys;
   logic        rst;
   logic        wp_n;
   logic [31:0] seed;
   logic [7:0]  mem [0:16383];
   logic [7:0]  rx;
   logic [7:0]  s;
   logic        oe;
   int          n_fail;
   int          cmp_count;
   wire logic   sck;
   wire logic   cs_n;
   wire logic   si;
   wire logic   hold_n;
   wire logic   so;
   wire logic   so_oe;
   wire logic   so_line;
   // undriven output reads as high impedance
   assign so_line = so_oe ? so : 1'hZ;
   always #50 clk_sys = ~clk_sys;
   sep_eeprom #(
      .WR_CYCLES(WR_N)
   ) i_sep_eeprom (
      .clk_sys_i(clk_sys), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n),
      .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
      .so_oe_o(so_oe)
   );
   sep_host i_sep_host (
      .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
      .so_i(so_line), .so_oe_i(so_oe)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // top regions locked by each guard code
   function automatic logic guarded(input logic [13:0] a,
                                    input logic [1:0] g);
      return g == 2'h3 || (g == 2'h2 && a >= 14'h2000) ||
         (g == 2'h1 && a >= 14'h3000);
   endfunction
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] got);
      cmp_count++;
      if (got !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic go(input logic [7:0] b);
      i_sep_host.xfer(b, rx, oe);
   endtask
   task automatic open_frame(input logic [7:0] op);
      @(negedge clk_sys);
      i_sep_host.start();
      go(op);
   endtask
   task automatic cmd(input logic [7:0] op);
      open_frame(op);
      i_sep_host.stop();
   endtask
   task automatic stat(output logic [7:0] v);
      open_frame(OP_STAT_RD | 8'h08);
      go(8'h00);
      v = rx;
      i_sep_host.stop();
   endtask
   // first poll checks the busy pattern, or the idle flag when no cycle is expected, then wait for ready
   task automatic settle(input logic busy);
      int k;
      stat(s);
      if (busy) begin
         chk("busy status", SR_BUSY_VALUE, s);
         cmd(OP_SET_LATCH);
      end else
         chk("idle flag", 8'h00, {7'h00, s[0]});
      k = 0;
      while (s[0] !== 1'h0 && k < 100) begin
         stat(s);
         k++;
      end
      if (s[0] !== 1'h0) begin
         n_fail++;
         $display("[ERR] write cycle expected to end, still busy");
         complete_run();
      end
   endtask
   // page write with a suspend after the address
   task automatic wr(input logic [15:0] a, input int n,
                     input logic [1:0] g, input logic en);
      logic [13:0] p;
      open_frame(OP_ARRAY_WR);
      go(a[15:8]);
      go(a[7:0]);
      i_sep_host.pause(3);
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         p = {a[13:6], 6'(a[5:0] + 6'(i))};
         if (en && !guarded(a[13:0], g))
            mem[p] = seed[7:0];
         go(seed[7:0]);
      end
      i_sep_host.stop();
      settle(en && !guarded(a[13:0], g));
   endtask
   task automatic rd(input logic [15:0] a, input int n);
      open_frame(OP_ARRAY_RD | 8'h08);
      go(a[15:8]);
      go(a[7:0]);
      for (int i = 0; i < n; i++) begin
         go(8'hA5);
         chk("array byte", mem[a[13:0] + 14'(i)], rx);
      end
      i_sep_host.stop();
   endtask
   task automatic status_write_cmd(input logic [7:0] v, input logic busy);
      open_frame(OP_STAT_WR);
      go(v);
      i_sep_host.stop();
      settle(busy);
   endtask
   initial begin
      clk_sys = 1'h0;
      rst = 1'h1;
      wp_n = 1'h1;
      n_fail = 0;
      cmp_count = 0;
      seed = 32'hE7B7A593;
      repeat (12) @(negedge clk_sys);
      rst = 1'h0;
      repeat (3) @(negedge clk_sys);
      stat(s);
      chk("status after reset", 8'h00, s);
      cmd(8'h0E);
      stat(s);
      chk("latch set", 8'h02, s);
      cmd(8'h0C);
      stat(s);
      chk("latch clear", 8'h00, s);
      wr(16'h0105, 1, 2'h0, 1'h0);
      // two wrapping pages, then reads across the top of the array
      cmd(OP_SET_LATCH);
      wr(16'hC005, 66, 2'h0, 1'h1);
      stat(s);
      chk("latch after cycle", 8'h00, s);
      cmd(OP_SET_LATCH);
      wr(16'hFFFA, 70, 2'h0, 1'h1);
      rd(16'h3FC0, 65);
      rd(16'h8000, 64);
      // every guard code against three region boundaries
      for (int g = 0; g < 4; g++) begin
         cmd(OP_SET_LATCH);
         status_write_cmd({4'h0, 2'(g), 2'h0}, 1'h1);
         stat(s);
         chk("guard status", {4'h0, 2'(g), 2'h0}, s);
         for (int j = 0; j < 3; j++) begin
            cmd(OP_SET_LATCH);
            wr(GA[j], 1, 2'(g), 1'h1);
         end
      end
      for (int j = 0; j < 3; j++)
         rd(GA[j], 1);
      // opcodes with the top bit set are refused
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         open_frame({1'h1, seed[6:0]});
         go(8'h00);
         chk("unknown opcode output", 8'h00, {7'h00, oe});
         i_sep_host.stop();
      end
      // arm the pin, then drop it in mid status write
      cmd(OP_SET_LATCH);
      status_write_cmd(8'h80, 1'h1);
      cmd(OP_SET_LATCH);
      open_frame(OP_STAT_WR);
      @(negedge clk_sys) wp_n = 1'h0;
      go(8'h00);
      // pin back high before the rise, so only the abort refuses it
      @(negedge clk_sys) wp_n = 1'h1;
      i_sep_host.stop();
      settle(1'h0);
      stat(s);
      chk("aborted status", 8'h82, s);
      // pin held low through a whole status write
      @(negedge clk_sys) wp_n = 1'h0;
      status_write_cmd(8'h00, 1'h0);
      stat(s);
      chk("protected status", 8'h82, s);
      @(negedge clk_sys) wp_n = 1'h1;
      status_write_cmd(8'h00, 1'h1);
      stat(s);
      chk("unprotected status", 8'h00, s);
      complete_run();
   end
endmodule
`default_nettype wire

// *** sep_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural host master, mode 0; clock idles low between frames
module sep_host (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o,
   output logic      hold_n_o,
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   localparam time HALF = 32ns;
   // idle levels
   initial begin
      sck_o = 1'h0;
      cs_n_o = 1'h1;
      si_o = 1'h0;
      hold_n_o = 1'h1;
   end
   task automatic start;
      cs_n_o = 1'h0;
      #(HALF);
   endtask
   // one byte each way, MSB first; oe high if any bit was driven
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                       output logic oe);
      oe = 1'h0;
      for (int i = 7; i >= 0; i--) begin
         si_o = tx[i];
         #(HALF) sck_o = 1'h1;
         rx[i] = so_i;
         oe = oe | so_oe_i;
         #(HALF) sck_o = 1'h0;
      end
   endtask
   // suspend only while clock is low; clock keeps toggling meanwhile
   task automatic pause(input int n);
      #(HALF / 2) hold_n_o = 1'h0;
      repeat (n) begin
         #(HALF) sck_o = 1'h1;
         #(HALF) sck_o = 1'h0;
      end
      #(HALF / 2) hold_n_o = 1'h1;
      #(HALF / 2);
   endtask
   // deselect in the low phase right after the last bit
   task automatic stop;
      #(HALF / 2) cs_n_o = 1'h1;
      si_o = ~si_o;
      #600ns;
   endtask
endmodule
`default_nettype wire

// *** sep_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

// two-clock memory, one write port and one registered read port
module sep_mem #(
   parameter int unsigned W  = 8,
   parameter int unsigned AW = 6
) (
   input  wire logic          wclk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [W-1:0]  wdata_i,
   input  wire logic          rclk_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [W-1:0]  rdata_o
);

   logic [W-1:0] cells [0:(1<<AW)-1];

   // write side
   always_ff @(posedge wclk_i) begin
      if (we_i) begin
         cells[waddr_i] <= wdata_i;
      end
   end

   // read data always leaves from a register
   always_ff @(posedge rclk_i) begin
      rdata_o <= cells[raddr_i];
   end

endmodule

`default_nettype wire

// *** sep_pkg.sv ***
package sep_pkg;

   // array and page geometry
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned PAGE_W = 6;
   localparam int unsigned BASE_W = ADDR_W - PAGE_W;
   localparam int unsigned PAGE_BYTES = 64;

   // opcodes after the don't-care bit is masked off
   localparam logic [7:0] OP_MASK = 8'hF7;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_ARRAY_RD = 8'h03;
   localparam logic [7:0] OP_ARRAY_WR = 8'h02;

   // status byte layout
   localparam int unsigned SR_BUSY_BIT = 0;
   localparam int unsigned SR_WEL_BIT = 1;
   localparam int unsigned SR_GUARD_LO_BIT = 2;
   localparam int unsigned SR_GUARD_HI_BIT = 3;
   localparam int unsigned SR_ARM_BIT = 7;
   localparam logic [7:0] SR_BUSY_VALUE = 8'hFF;

   // block guard codes
   localparam logic [1:0] GUARD_NONE = 2'h0;
   localparam logic [1:0] GUARD_QUARTER = 2'h1;
   localparam logic [1:0] GUARD_HALF = 2'h2;
   localparam logic [1:0] GUARD_ALL = 2'h3;

   // reset values of the status fields
   localparam logic WEL_RESET = 1'b0;
   localparam logic [1:0] GUARD_RESET = 2'h0;
   localparam logic ARM_RESET = 1'b0;

   // self-timed write cycle, a longest time so it rounds down
   localparam int unsigned WR_CYCLE_MS = 5;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned WR_CYCLE_CNT =
      (WR_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

   // link-side sequencer states
   typedef enum logic [2:0] {
      LS_OPCODE,
      LS_ADDR,
      LS_RDATA,
      LS_STAT,
      LS_SWR,
      LS_WDATA,
      LS_TAIL,
      LS_IGNORE
   } sep_link_state_t;

   // command handed from the link to the system side
   typedef enum logic [1:0] {
      CK_SET,
      CK_CLR,
      CK_STAT,
      CK_PAGE
   } sep_cmd_t;

endpackage
